// file: tb/hash_engine_model.sv
// Purpose: stand-in hash engine, digest = key xor message
// Assumes: requests are one-cycle pulses
// Notes: digest shows a wrong pattern outside the done cycle
`timescale 1ns/1ns
`default_nettype none
module hash_engine_model #(
  parameter int LAT = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // engine port
  input wire logic hash_req_q,
  input wire logic [255:0] hash_key_q,
  input wire logic [255:0] hash_msg_q,
  output var logic hash_done,
  output logic [255:0] hash_digest
);
  logic [255:0] res_q;
  int cnt;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      res_q <= 256'h0;
      hash_done <= 1'b0;
    end
    else
    begin
      hash_done <= (cnt == 1);
      if (hash_req_q)
      begin
        res_q <= hash_key_q ^ hash_msg_q;
        cnt <= LAT;
      end
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
  assign hash_digest = hash_done ? res_q : ~res_q;
endmodule // hash_engine_model
`default_nettype wire

// file: tb/key_setup_monitor.sv
// Purpose: port assertions for the key setup block
// Assumes: bound to replay_protected_counter_unit_key_setup, one clock domain
// Notes: watches design outputs only
`timescale 1ns/1ns
`default_nettype none
module key_setup_monitor (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // observed outputs
  input wire hash_req_q,
  input wire [7:0] status_q,
  input wire busy,
  input wire [3:0] root_key_uninit_q,
  input wire [3:0] counter_init_flags_q,
  input wire [3:0] hmac_key_valid_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start;
    $rose(busy) && hash_req_q;
  endsequence
  sequence s_post;
    !busy && (status_q[7] || status_q[3]);
  endsequence
  a_busy_mirror: assert property (busy |-> (status_q & 8'hB6) == 8'h00)
    else $error("result bits shown while busy");
  a_run_ends: assert property (s_start |-> busy [*2] ##[1:400] s_post)
    else $error("busy run did not end with a result");
  a_hash_pulse: assert property (hash_req_q |=> !hash_req_q)
    else $error("hash request longer than one cycle");
  a_err_idle: assert property ($rose(|{status_q[5:4], status_q[2:1]}) |-> !busy && !hash_req_q)
    else $error("check error posted while busy or hashing");
  a_ok_idle: assert property ($rose(status_q[7]) |-> !busy)
    else $error("success posted while busy");
  a_key_monotone: assert property ((root_key_uninit_q & ~$past(root_key_uninit_q)) == 4'h0)
    else $error("root key flag set again");
  a_key_last: assert property ((root_key_uninit_q != $past(root_key_uninit_q)) |-> status_q == 8'h80)
    else $error("root key flag changed without success");
  a_init_sticky: assert property ((~counter_init_flags_q & $past(counter_init_flags_q)) == 4'h0)
    else $error("counter init flag lost");
  a_hmac_needs_init: assert property ((hmac_key_valid_q & ~counter_init_flags_q) == 4'h0)
    else $error("hmac key valid on uninitialized counter");
endmodule // key_setup_monitor
bind replay_protected_counter_unit_key_setup key_setup_monitor mon (.core_clk(core_clk), .rst(rst), .hash_req_q(hash_req_q),
  .status_q(status_q), .busy(busy), .root_key_uninit_q(root_key_uninit_q),
  .counter_init_flags_q(counter_init_flags_q), .hmac_key_valid_q(hmac_key_valid_q));
`default_nettype wire

// file: tb/test_replay_protected_counter_unit_key_setup.sv
// Purpose: self-checking bench for the key setup block
// Assumes: inputs change at the falling edge
// Notes: busy window shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module test_replay_protected_counter_unit_key_setup;
  localparam int BUSY_N = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic frame_start = 1'b0;
  logic byte_valid = 1'b0;
  logic frame_end = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] byte_data = 8'h00;
  logic [1:0] counter_rd_addr = 2'h0;
  logic hash_req_q, hash_done, busy;
  logic [255:0] hash_key_q, hash_msg_q, hash_digest, dig;
  logic [7:0] status_q;
  logic [31:0] counter_rd_data_q;
  logic [3:0] root_key_uninit_q, counter_init_flags_q, hmac_key_valid_q;
  logic [7:0] pl [0:69];
  logic [255:0] k1 = {8{32'h5A3C_96E1}};
  int errors = 0;
  int tests_run = 0;
  int busy_len;
  always #2 core_clk = ~core_clk;
  replay_protected_counter_unit_key_setup #(.NUM_COUNTERS(4), .BUSY_WIDTH(17), .BUSY_CYCLES(17'd20)) DUT (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .frame_start(frame_start),
    .byte_valid(byte_valid), .byte_data(byte_data), .frame_end(frame_end),
    .hash_req_q(hash_req_q), .hash_key_q(hash_key_q), .hash_msg_q(hash_msg_q),
    .hash_done(hash_done), .hash_digest(hash_digest), .status_q(status_q), .busy(busy),
    .counter_rd_addr(counter_rd_addr), .counter_rd_data_q(counter_rd_data_q),
    .root_key_uninit_q(root_key_uninit_q), .counter_init_flags_q(counter_init_flags_q),
    .hmac_key_valid_q(hmac_key_valid_q));
  hash_engine_model #(.LAT(4)) engine (.core_clk(core_clk), .rst(rst), .hash_req_q(hash_req_q),
    .hash_key_q(hash_key_q), .hash_msg_q(hash_msg_q), .hash_done(hash_done),
    .hash_digest(hash_digest));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic head(input logic [7:0] sub, input logic [7:0] addr);
    pl[0] = 8'h9B;
    pl[1] = sub;
    pl[2] = addr;
    pl[3] = 8'h00;
  endtask
  // frame out, then wait for the result with busy counted
  task automatic send(input int len, input logic [7:0] exp);
    int i;
    busy_len = 0;
    @(negedge core_clk);
    frame_start = 1'b1;
    @(negedge core_clk);
    frame_start = 1'b0;
    for (i = 0; i < len; i++)
    begin
      byte_valid = 1'b1;
      byte_data = pl[i];
      @(negedge core_clk);
    end
    byte_valid = 1'b0;
    frame_end = 1'b1;
    @(negedge core_clk);
    frame_end = 1'b0;
    @(negedge core_clk);
    while (busy === 1'b1 && busy_len < 500)
    begin
      busy_len++;
      @(negedge core_clk);
    end
    check(status_q, exp);
  endtask
  task automatic rk_frame(input logic [7:0] addr, input logic [255:0] key);
    int i;
    head(8'h00, addr);
    dig = key ^ {224'h0, pl[3], pl[2], pl[1], pl[0]};
    for (i = 0; i < 32; i++)
      pl[4 + i] = key[8 * i +: 8];
    for (i = 0; i < 28; i++)
      pl[36 + i] = dig[8 * i +: 8];
  endtask
  task automatic hk_frame(input logic [7:0] addr, input logic [31:0] kd, input logic [255:0] key);
    int i;
    head(8'h01, addr);
    dig = key ^ {224'h0, kd} ^ {208'h0, addr, 8'h01, kd};
    for (i = 0; i < 4; i++)
      pl[4 + i] = kd[8 * i +: 8];
    for (i = 0; i < 32; i++)
      pl[8 + i] = dig[8 * i +: 8];
  endtask
  task automatic t_refusals;
    check({status_q, root_key_uninit_q, counter_init_flags_q}, 16'h00F0);
    head(8'h04, 8'h00);
    send(64, 8'h04);
    pl[0] = 8'h96;
    send(64, 8'h04);
    rk_frame(8'h04, k1);
    // frozen core must leave the status untouched
    clk_en = 1'b0;
    send(64, 8'h04);
    clk_en = 1'b1;
    send(64, 8'h02);
    rk_frame(8'h00, k1);
    send(63, 8'h02);
    hk_frame(8'h02, 32'h1234_5678, k1);
    send(40, 8'h20);
    $display("test refusals done");
  endtask
  task automatic t_temp_key;
    rk_frame(8'h00, {256{1'b1}});
    pl[40] = ~pl[40];
    send(64, 8'h08);
    rk_frame(8'h00, {256{1'b1}});
    send(64, 8'h80);
    check({root_key_uninit_q, counter_init_flags_q}, 8'hF1);
    send(64, 8'h80);
    counter_rd_addr = 2'h0;
    repeat (2) @(negedge core_clk);
    check(counter_rd_data_q, 32'h0);
    $display("test temporary key done");
  endtask
  task automatic t_root_key;
    rk_frame(8'h01, k1);
    send(64, 8'h80);
    check({root_key_uninit_q, counter_init_flags_q}, 8'hD3);
    rk_frame(8'h01, ~k1);
    send(64, 8'h10);
    $display("test root key done");
  endtask
  task automatic t_hmac;
    hk_frame(8'h01, 32'hA5C3_0F1E, k1);
    send(39, 8'h02);
    pl[20] = ~pl[20];
    send(40, 8'h08);
    check(hmac_key_valid_q, 4'h0);
    hk_frame(8'h01, 32'hA5C3_0F1E, k1);
    send(40, 8'h80);
    check(hmac_key_valid_q, 4'h2);
    check(busy_len >= BUSY_N, 1);
    $display("test hmac update done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_refusals();
    t_temp_key();
    t_root_key();
    t_hmac();
    complete_run();
  end
endmodule // test_replay_protected_counter_unit_key_setup
`default_nettype wire

// file: verilog/busy_timer.v
// Purpose: holds a minimum busy window after a start pulse
// Assumes: start is a one-cycle pulse
// Notes: expired is high whenever no window is running
`timescale 1ns/1ns
`default_nettype none
module busy_timer #(
  parameter WIDTH = 17,
  parameter [WIDTH-1:0] CYCLES = 17'd80000
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // control
  input wire start,
  output wire expired
);
  reg [WIDTH-1:0] count_q;

  assign expired = (count_q == {WIDTH{1'b0}});

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_q <= {WIDTH{1'b0}};
    else if (clk_en)
    begin
      if (start)
        count_q <= CYCLES;
      else if (!expired)
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // busy_timer
`default_nettype wire

// file: verilog/payload_collector.v
// Purpose: gathers the bytes of one frame into a flat payload and counts them
// Assumes: byte strobes are synchronous to core_clk
// Notes: bytes past the payload limit are counted (saturating) but not stored
`timescale 1ns/1ns
`default_nettype none
`include "replay_protected_counter_unit_regs.vh"
module payload_collector #(
  parameter MAX_BYTES = `REPLAY_PROTECTED_COUNTER_UNIT_MAX_LEN
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // byte stream
  input wire frame_start,
  input wire byte_valid,
  input wire [7:0] byte_data,
  // collected frame
  output reg [8*MAX_BYTES-1:0] payload_q,
  output reg [6:0] byte_count_q
);
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      payload_q <= {8*MAX_BYTES{1'b0}};
      byte_count_q <= 7'h00;
    end
    else if (clk_en)
    begin
      if (frame_start)
        byte_count_q <= 7'h00;
      else if (byte_valid)
      begin
        if (byte_count_q < MAX_BYTES)
          payload_q[8*byte_count_q +: 8] <= byte_data;
        if (byte_count_q != 7'h7F)
          byte_count_q <= byte_count_q + 7'h01;
      end
    end
  end
endmodule // payload_collector
`default_nettype wire

// file: verilog/replay_protected_counter_unit_key_setup.v
// Purpose: checks and carries out root key writes and HMAC key updates
// Assumes: a front end delivers frame bytes; an external engine computes HMAC-SHA-256
// Notes: key and init-state storage is held here; persistence is the storage's task
// How it works
// - sub-type 00h writes the root key of the addressed counter.
// - root key write needs exactly 64 payload bytes, opcode included.
// - both commands reject counter addresses beyond the supported counters.
// - root key write only while that counter's root key is uninitialized.
// - root key write compares truncated signature to low 224 digest bits.
// - fully checked commands execute and post successful completion.
// - root key init flag is cleared as the last step of the write.
// - all-ones key is temporary: only zeroes an uninitialized counter.
// - any good root key write keeps an initialized counter's value.
// - after a real key, further writes refused; key never read out.
// - sub-type 01h replaces the HMAC key with one derived from input.
// - HMAC key update stays busy about twice the polling delay.
// - HMAC key update needs exactly 40 payload bytes, opcode included.
// - HMAC key update needs an initialized counter.
// - HMAC key update checks signature, two HMAC computations in all.
// - failing commands are not executed and post their error bit.
// - counter commands use opcode 9Bh; status polled with opcode 96h.
// - four counters, advertised as count minus one (3); range check uses this value.
// - each counter is 32 bits wide.
// - polling delay is ten units of 16 us; busy time derives from it.
`timescale 1ns/1ns
`default_nettype none
`include "replay_protected_counter_unit_regs.vh"
module replay_protected_counter_unit_key_setup #(
  parameter NUM_COUNTERS = 4,
  parameter BUSY_WIDTH = 17,
  parameter [BUSY_WIDTH-1:0] BUSY_CYCLES = `REPLAY_PROTECTED_COUNTER_UNIT_HMAC_UPDATE_BUSY_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // frame bytes from the serial front end
  input wire frame_start,
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire frame_end,
  // hash engine
  output reg hash_req_q,
  output reg [255:0] hash_key_q,
  output reg [255:0] hash_msg_q,
  input wire hash_done,
  input wire [255:0] hash_digest,
  // status and counter observation
  output reg [7:0] status_q,
  output wire busy,
  input wire [1:0] counter_rd_addr,
  output reg [31:0] counter_rd_data_q,
  output reg [NUM_COUNTERS-1:0] root_key_uninit_q,
  output reg [NUM_COUNTERS-1:0] counter_init_flags_q,
  output reg [NUM_COUNTERS-1:0] hmac_key_valid_q
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ROOT_HASH = 3'h1;
  localparam [2:0] ST_DERIVE = 3'h2;
  localparam [2:0] ST_SIGN = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;

  wire [8*`REPLAY_PROTECTED_COUNTER_UNIT_MAX_LEN-1:0] payload;
  wire [6:0] byte_count;
  wire timer_expired;
  reg [2:0] state_q;
  reg [1:0] addr_q;
  reg [255:0] new_key_q;
  reg [31:0] key_data_q;
  reg [223:0] trunc_sig_q;
  reg [255:0] full_sig_q;
  reg timer_start;
  reg [255:0] root_key_q [0:NUM_COUNTERS-1];
  reg [255:0] hmac_key_q [0:NUM_COUNTERS-1];
  reg [31:0] counter_q [0:NUM_COUNTERS-1];
  integer i;

  wire [7:0] opcode = payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_HEADER +: 8];
  wire [7:0] subtype = payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_SUBTYPE +: 8];
  wire [7:0] rx_addr = payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_ADDR +: 8];
  wire [1:0] rx_idx = rx_addr[1:0];
  wire cmd_frame = frame_end && (byte_count != 7'h00) &&
    (opcode == `REPLAY_PROTECTED_COUNTER_UNIT_OPCODE_COUNTER_CMD);
  wire addr_ok = (rx_addr <= {4'h0, `REPLAY_PROTECTED_COUNTER_UNIT_COUNTER_COUNT_M1});

  // post a result: error bits or success, busy dropped
  function [7:0] result;
    input [7:0] err;
    begin
      result = err;
      if (err == 8'h00)
        result[`REPLAY_PROTECTED_COUNTER_UNIT_ST_SUCCESS] = 1'b1;
      result[`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY] = 1'b0;
    end
  endfunction

  function [7:0] one_bit;
    input integer pos;
    begin
      one_bit = 8'h00;
      one_bit[pos] = 1'b1;
    end
  endfunction

  assign busy = status_q[`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY];

  payload_collector #(
    .MAX_BYTES(`REPLAY_PROTECTED_COUNTER_UNIT_MAX_LEN)
  ) u_collect (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .frame_start(frame_start),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .payload_q(payload),
    .byte_count_q(byte_count)
  );

  busy_timer #(
    .WIDTH(BUSY_WIDTH),
    .CYCLES(BUSY_CYCLES)
  ) u_busy (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .start(timer_start),
    .expired(timer_expired)
  );

  // the HMAC update busy window starts at acceptance
  always @*
  begin
    timer_start = 1'b0;
    if (state_q == ST_IDLE && cmd_frame && subtype == `REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_HMAC_UPDATE &&
      byte_count == `REPLAY_PROTECTED_COUNTER_UNIT_HMAC_UPDATE_LEN && addr_ok && counter_init_flags_q[rx_idx])
      timer_start = 1'b1;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      addr_q <= 2'h0;
      new_key_q <= 256'h0;
      key_data_q <= 32'h0;
      trunc_sig_q <= 224'h0;
      full_sig_q <= 256'h0;
      hash_req_q <= 1'b0;
      hash_key_q <= 256'h0;
      hash_msg_q <= 256'h0;
      status_q <= `REPLAY_PROTECTED_COUNTER_UNIT_STATUS_RESET;
      counter_rd_data_q <= 32'h0;
      root_key_uninit_q <= {NUM_COUNTERS{1'b1}};
      counter_init_flags_q <= {NUM_COUNTERS{1'b0}};
      hmac_key_valid_q <= {NUM_COUNTERS{1'b0}};
      for (i = 0; i < NUM_COUNTERS; i = i + 1)
      begin
        root_key_q[i] <= 256'h0;
        hmac_key_q[i] <= 256'h0;
        counter_q[i] <= 32'h0;
      end
    end
    else if (clk_en)
    begin
      hash_req_q <= 1'b0;
      counter_rd_data_q <= counter_q[counter_rd_addr];
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_frame)
          begin
            addr_q <= rx_idx;
            if (subtype == `REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_ROOT_KEY)
            begin
              if (byte_count != `REPLAY_PROTECTED_COUNTER_UNIT_ROOT_KEY_LEN || !addr_ok)
                status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_RANGE_ERR));
              else if (!root_key_uninit_q[rx_idx])
                status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_KEY_STATE_ERR));
              else
              begin
                new_key_q <= payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_ROOT_KEY +: 256];
                trunc_sig_q <= payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_TRUNC_SIG +: `REPLAY_PROTECTED_COUNTER_UNIT_TRUNC_SIG_BITS];
                hash_key_q <= payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_ROOT_KEY +: 256];
                hash_msg_q <= {224'h0, payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_HEADER +: 32]};
                hash_req_q <= 1'b1;
                status_q <= one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY);
                state_q <= ST_ROOT_HASH;
              end
            end
            else if (subtype == `REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_HMAC_UPDATE)
            begin
              if (byte_count != `REPLAY_PROTECTED_COUNTER_UNIT_HMAC_UPDATE_LEN || !addr_ok)
                status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_RANGE_ERR));
              else if (!counter_init_flags_q[rx_idx])
                status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_COUNTER_INIT_ERR));
              else
              begin
                key_data_q <= payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_KEY_DATA +: 32];
                full_sig_q <= payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_FULL_SIG +: 256];
                hash_key_q <= root_key_q[rx_idx];
                hash_msg_q <= {224'h0, payload[`REPLAY_PROTECTED_COUNTER_UNIT_POS_KEY_DATA +: 32]};
                hash_req_q <= 1'b1;
                status_q <= one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY);
                state_q <= ST_DERIVE;
              end
            end
            else if (subtype >= `REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_FIRST_RESERVED)
              status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_RESERVED_CMD));
          end
        end
        ST_ROOT_HASH:
        begin
          if (hash_done)
          begin
            state_q <= ST_IDLE;
            if (hash_digest[`REPLAY_PROTECTED_COUNTER_UNIT_TRUNC_SIG_BITS-1:0] != trunc_sig_q)
              status_q <= result(one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_SIG_ERR));
            else
            begin
              status_q <= result(8'h00);
              if (!counter_init_flags_q[addr_q])
              begin
                counter_q[addr_q] <= 32'h0;
                counter_init_flags_q[addr_q] <= 1'b1;
              end
              if (new_key_q != {256{1'b1}})
              begin
                root_key_q[addr_q] <= new_key_q;
                root_key_uninit_q[addr_q] <= 1'b0;
              end
            end
          end
        end
        ST_DERIVE:
        begin
          if (hash_done)
          begin
            new_key_q <= hash_digest;
            hash_key_q <= hash_digest;
            // address and key data come from latched state, sub-type is a constant; a status poll frame may
            // arrive during busy and overwrite the collected payload
            hash_msg_q <= {208'h0, 6'h0, addr_q, `REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_HMAC_UPDATE, key_data_q};
            hash_req_q <= 1'b1;
            state_q <= ST_SIGN;
          end
        end
        ST_SIGN:
        begin
          if (hash_done)
          begin
            if (hash_digest != full_sig_q)
              status_q <= one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_SIG_ERR) | one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY);
            else
            begin
              hmac_key_q[addr_q] <= new_key_q;
              hmac_key_valid_q[addr_q] <= 1'b1;
            end
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (timer_expired)
          begin
            status_q <= result(status_q & ~one_bit(`REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY));
            state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // replay_protected_counter_unit_key_setup
`default_nettype wire

// file: verilog/replay_protected_counter_unit_regs.vh
// Purpose: shared constants of the replay-protected counter key setup logic
// Assumes: included by bare name from the design files
// Notes: timing figures are kept in their own units; cycle counts derive from them
`ifndef REPLAY_PROTECTED_COUNTER_UNIT_REGS_VH
`define REPLAY_PROTECTED_COUNTER_UNIT_REGS_VH

// opcodes and command sub-types
`define REPLAY_PROTECTED_COUNTER_UNIT_OPCODE_COUNTER_CMD 8'h9B
`define REPLAY_PROTECTED_COUNTER_UNIT_OPCODE_STATUS_READ 8'h96
`define REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_ROOT_KEY 8'h00
`define REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_HMAC_UPDATE 8'h01
`define REPLAY_PROTECTED_COUNTER_UNIT_SUBTYPE_FIRST_RESERVED 8'h04

// payload sizes in bytes, counter opcode byte included
`define REPLAY_PROTECTED_COUNTER_UNIT_ROOT_KEY_LEN 7'd64
`define REPLAY_PROTECTED_COUNTER_UNIT_HMAC_UPDATE_LEN 7'd40
`define REPLAY_PROTECTED_COUNTER_UNIT_MAX_LEN 64

// payload field bit offsets (byte i occupies bits [8*i+7:8*i])
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_SUBTYPE 8
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_ADDR 16
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_HEADER 0
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_ROOT_KEY 32
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_TRUNC_SIG 288
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_KEY_DATA 32
`define REPLAY_PROTECTED_COUNTER_UNIT_POS_FULL_SIG 64
`define REPLAY_PROTECTED_COUNTER_UNIT_TRUNC_SIG_BITS 224

// counters: advertised count minus one, counter width
`define REPLAY_PROTECTED_COUNTER_UNIT_COUNTER_COUNT_M1 4'h3
`define REPLAY_PROTECTED_COUNTER_UNIT_COUNTER_BITS 32

// counter status bits
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_BUSY 0
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_RANGE_ERR 1
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_RESERVED_CMD 2
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_SIG_ERR 3
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_KEY_STATE_ERR 4
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_COUNTER_INIT_ERR 5
`define REPLAY_PROTECTED_COUNTER_UNIT_ST_SUCCESS 7
`define REPLAY_PROTECTED_COUNTER_UNIT_STATUS_RESET 8'h00

// typical read-counter polling delay: 5-bit count, unit code 01 selects 16 us
`define REPLAY_PROTECTED_COUNTER_UNIT_POLL_DELAY_COUNT 5'h0A
`define REPLAY_PROTECTED_COUNTER_UNIT_POLL_UNIT_CODE 2'h1
`define REPLAY_PROTECTED_COUNTER_UNIT_POLL_UNIT_US 16
`define REPLAY_PROTECTED_COUNTER_UNIT_CLOCK_MHZ 250
`define REPLAY_PROTECTED_COUNTER_UNIT_HMAC_UPDATE_BUSY_CYCLES (2 * 10 * `REPLAY_PROTECTED_COUNTER_UNIT_POLL_UNIT_US * `REPLAY_PROTECTED_COUNTER_UNIT_CLOCK_MHZ)

`endif
